// ===== rtl/mdc_pkg.sv
// Package for the multichannel decimation core: profiles, ratios, timing counts, carrier structs
package mdc_pkg;

    // ****************************************************************
    // Operating profiles
    // ****************************************************************
    typedef enum logic [1:0] {
        HIGH_SPEED_PROFILE,
        HIGH_RESOLUTION_PROFILE,
        LOW_POWER_PROFILE,
        LOW_SPEED_PROFILE
    } mdc_profile_e;

    // ****************************************************************
    // Sizes and ratios
    // ****************************************************************
    localparam int unsigned WORD_W      = 24;          // Result width
    localparam int unsigned CHAN_MAX    = 8;           // Octal part
    localparam int unsigned OSR_STD     = 64;          // Standard decimation
    localparam int unsigned OSR_HRES    = 128;         // High-resolution decimation
    localparam int unsigned DIV_FAST    = 4;           // Master clock divisors
    localparam int unsigned DIV_MID     = 8;
    localparam int unsigned DIV_SLOW    = 40;
    localparam int unsigned SETTLE_STD  = 76;          // Output periods to settle
    localparam int unsigned SETTLE_HRES = 78;

    // ****************************************************************
    // Output word rates per second, for reference
    // ****************************************************************
    localparam int unsigned RATE_HS = 128000;
    localparam int unsigned RATE_HR = 52734;
    localparam int unsigned RATE_LP = 52734;
    localparam int unsigned RATE_LS = 10547;

    // ****************************************************************
    // Saturation codes
    // ****************************************************************
    localparam logic [23:0] CODE_POS_MAX = 24'h7fffff;
    localparam logic [23:0] CODE_NEG_MAX = 24'h800000;

    // ****************************************************************
    // Serial port format
    // ****************************************************************
    typedef enum logic {
        FMT_SPI,
        FMT_FRAME_SYNC
    } mdc_format_e;

    // Static configuration pins, grouped
    typedef struct packed {
        mdc_profile_e profile;
        logic         clock_divide_select;
        logic         bypass;
        mdc_format_e  format;
    } mdc_cfg_s;

endpackage

// ===== rtl/mdc_core.sv
// Multichannel decimation core: modulator clocking, sinc^3 decimators, serial readout
`timescale 1ns/1ps
// ****************************************************************
// ****************************************************************
module mdc_core
    import mdc_pkg::*;
#(
    parameter int unsigned NCH = CHAN_MAX            // Four or eight channels
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // Static configuration pins
    input  wire mdc_cfg_s         cfg_i,
    // Modulator bit streams, one per channel, on the master clock
    input  wire logic [NCH-1:0]   mod_bit_i,
    // External synchronisation pin
    input  wire logic             sync_i,
    // Serial port
    input  wire logic             sclk_i,
    input  wire logic             fsync_i,
    input  wire logic             din_i,
    output logic                  dout_o,
    output logic                  data_ready_b_o,
    // Status
    output logic                  mod_strobe_o,
    output logic                  settled_o,
    output logic [NCH*WORD_W-1:0] words_o
);

    localparam int unsigned ACC_W = 24;              // 3*log2(128)+1 = 22 bits fit
    localparam int unsigned SH_W  = NCH*WORD_W;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [2:0]             sclk_s;               // Three-stage synchronisers
        logic [2:0]             fs_s;
        logic [2:0]             din_s;
        logic [2:0]             sync_s;
        logic [5:0]             div_cnt;              // Modulator divider
        logic [7:0]             dec_cnt;              // Decimation phase
        logic [6:0]             settle_cnt;           // Output periods since restart
        mdc_cfg_s               cfg_last;             // For change detection
        logic [NCH-1:0][ACC_W-1:0] i1, i2, i3;       // Integrators
        logic [NCH-1:0][ACC_W-1:0] c1, c2, c3;       // Comb delays
        logic [NCH-1:0][WORD_W-1:0] word;            // Latched results
        logic [SH_W-1:0]        shreg;                // Output shifter
        logic                   drdy_b;
        logic                   strobe;
        logic                   cfg_valid;
    } mdc_state_s;

    mdc_state_s s_q;                                 // Registered state
    mdc_state_s s_d;                                 // Next state

    // Divisor per profile and divide pin
    function automatic logic [5:0] mod_div(input mdc_cfg_s c);
        case (c.profile)
            LOW_POWER_PROFILE: mod_div = c.clock_divide_select ? 6'(DIV_MID) : 6'(DIV_FAST);
            LOW_SPEED_PROFILE: mod_div = c.clock_divide_select ? 6'(DIV_SLOW) : 6'(DIV_MID);
            default:           mod_div = 6'(DIV_FAST);
        endcase
    endfunction

    // Saturate a filter output into a signed 24-bit code
    function automatic logic [WORD_W-1:0] sat24(input logic signed [ACC_W+1:0] v);
        if (v > $signed({2'b00, CODE_POS_MAX}))
            sat24 = CODE_POS_MAX;
        else if (v < $signed({{2{1'b1}}, CODE_NEG_MAX}))
            sat24 = CODE_NEG_MAX;
        else
            sat24 = v[WORD_W-1:0];
    endfunction

    // Decoded helpers
    logic [7:0] osr;                                 // Current ratio minus nothing
    logic [6:0] settle_need;                         // Periods to settle
    logic       cfg_chg;                             // Pins moved or sync edge
    logic       sclk_rise;
    logic       fs_rise;
    logic       word_done;                           // Output period ends this cycle

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic signed [ACC_W+1:0] y;                  // Scaled comb output
        logic [ACC_W-1:0]        d1, d2, d3;
        y  = '0;
        d1 = '0;
        d2 = '0;
        d3 = '0;
        s_d = s_q;
        word_done = 1'b0;
        osr = (cfg_i.profile == HIGH_RESOLUTION_PROFILE) ? 8'(OSR_HRES) : 8'(OSR_STD);
        settle_need = (cfg_i.profile == HIGH_RESOLUTION_PROFILE) ? 7'(SETTLE_HRES) : 7'(SETTLE_STD);
        // Rise seen once the second stage is high and the third still low
        sclk_rise = s_q.sclk_s[1] & ~s_q.sclk_s[2];
        fs_rise   = s_q.fs_s[1] & ~s_q.fs_s[2];
        // Pins are asynchronous but static; a move restarts the filters
        cfg_chg   = (cfg_i != s_q.cfg_last) | (s_q.sync_s[1] & ~s_q.sync_s[2]);
        // Synchronisers
        s_d.sclk_s = {s_q.sclk_s[1:0], sclk_i};
        s_d.fs_s   = {s_q.fs_s[1:0], fsync_i};
        s_d.din_s  = {s_q.din_s[1:0], din_i};
        s_d.sync_s = {s_q.sync_s[1:0], sync_i};
        s_d.cfg_last  = cfg_i;
        s_d.cfg_valid = 1'b1;
        s_d.strobe    = 1'b0;

        if (cfg_chg || !s_q.cfg_valid) begin
            // Restart every filter together; keeps channels phase aligned
            s_d.div_cnt    = '0;
            s_d.dec_cnt    = '0;
            s_d.settle_cnt = '0;
            s_d.i1 = '0;
            s_d.i2 = '0;
            s_d.i3 = '0;
            s_d.c1 = '0;
            s_d.c2 = '0;
            s_d.c3 = '0;
        end else begin
            // Modulator tick from the shared master clock
            if (s_q.div_cnt == mod_div(cfg_i) - 6'd1) begin
                s_d.div_cnt = '0;
                s_d.strobe  = 1'b1;
            end else begin
                s_d.div_cnt = s_q.div_cnt + 6'd1;
            end
            if (s_d.strobe) begin
                for (int ch = 0; ch < NCH; ch++) begin
                    // Bit 1 maps to +1, bit 0 to -1: density gives the level
                    s_d.i1[ch] = s_q.i1[ch] + (mod_bit_i[ch] ? ACC_W'(1) : {ACC_W{1'b1}});
                    s_d.i2[ch] = s_q.i2[ch] + s_q.i1[ch];
                    s_d.i3[ch] = s_q.i3[ch] + s_q.i2[ch];
                end
                if (s_q.dec_cnt == osr - 8'd1) begin
                    s_d.dec_cnt = '0;
                    for (int ch = 0; ch < NCH; ch++) begin
                        // Three comb stages, one per decimated sample
                        d1 = s_q.i3[ch] - s_q.c1[ch];
                        d2 = d1 - s_q.c2[ch];
                        d3 = d2 - s_q.c3[ch];
                        s_d.c1[ch] = s_q.i3[ch];
                        s_d.c2[ch] = d1;
                        s_d.c3[ch] = d2;
                        // Gain is osr^3; full-scale density must reach 2^23 so it clips
                        if (cfg_i.profile == HIGH_RESOLUTION_PROFILE)
                            y = $signed({{2{d3[ACC_W-1]}}, d3}) <<< 2;
                        else
                            y = $signed({{2{d3[ACC_W-1]}}, d3}) <<< 5;
                        s_d.word[ch] = cfg_i.bypass ? {{(WORD_W-1){1'b0}}, mod_bit_i[ch]}
                                                    : sat24(y);
                    end
                    // One shared ready and shifter load for all channels
                    s_d.drdy_b = 1'b0;
                    word_done  = 1'b1;
                    if (s_q.settle_cnt < settle_need)
                        s_d.settle_cnt = s_q.settle_cnt + 7'd1;
                end else begin
                    s_d.dec_cnt = s_q.dec_cnt + 8'd1;
                    // Unread word: raise ready one tick early so the next word still gives a fall
                    if (s_q.dec_cnt == osr - 8'd2)
                        s_d.drdy_b = 1'b1;
                end
                if (cfg_i.bypass)
                    for (int ch = 0; ch < NCH; ch++)
                        s_d.word[ch] = {{(WORD_W-1){1'b0}}, mod_bit_i[ch]};
            end
        end

        // Serial port: load on a new word, shift MSB first on SCLK
        // Frame-sync reads load only on the sync edge, so a frame is never cut by a new word
        if (word_done && cfg_i.format == FMT_SPI) begin
            s_d.shreg = s_d.word;
        end else if (cfg_i.format == FMT_FRAME_SYNC && fs_rise) begin
            s_d.shreg = s_q.word;
        end else if (sclk_rise) begin
            // Daisy-chain: downstream data enters behind our own
            s_d.shreg  = {s_q.shreg[SH_W-2:0], s_q.din_s[2]};
            // A new word in the same cycle wins over the clear
            if (!word_done)
                s_d.drdy_b = 1'b1;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q        <= '0;
            s_q.drdy_b <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign dout_o         = s_q.shreg[SH_W-1];
    assign data_ready_b_o = s_q.drdy_b;
    assign mod_strobe_o   = s_q.strobe;
    assign settled_o      = (s_q.settle_cnt >= settle_need);
    assign words_o        = s_q.word;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_restart;
        cfg_chg;
    endsequence

    property p_restart_clears;
        @(posedge clk_i) disable iff (!rst_b_i) s_restart |=> (s_q.dec_cnt == 8'd0 && !settled_o);
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear");

    property p_div_bound;
        @(posedge clk_i) disable iff (!rst_b_i) s_q.div_cnt < 6'(DIV_SLOW);
    endproperty
    a_div_bound: assert property (p_div_bound) else $error("divider out of range");

    property p_dec_bound;
        @(posedge clk_i) disable iff (!rst_b_i) s_q.dec_cnt < 8'(OSR_HRES);
    endproperty
    a_dec_bound: assert property (p_dec_bound) else $error("decimator phase out of range");

    property p_hs_strobe;
        @(posedge clk_i) disable iff (!rst_b_i)
            (mod_strobe_o && $stable(cfg_i) && cfg_i.profile == HIGH_SPEED_PROFILE && !cfg_chg)
            |=> !mod_strobe_o [*3];
    endproperty
    a_hs_strobe: assert property (p_hs_strobe) else $error("high-speed strobe spacing");

    property p_ready_on_strobe;
        @(posedge clk_i) disable iff (!rst_b_i) $fell(data_ready_b_o) |-> $past(s_d.strobe, 1) || mod_strobe_o;
    endproperty
    a_ready_on_strobe: assert property (p_ready_on_strobe) else $error("ready without tick");

    property p_settle_cap;
        @(posedge clk_i) disable iff (!rst_b_i) s_q.settle_cnt <= 7'(SETTLE_HRES);
    endproperty
    a_settle_cap: assert property (p_settle_cap) else $error("settle count overrun");

    property p_load_msb;
        @(posedge clk_i) disable iff (!rst_b_i)
            ($fell(data_ready_b_o) && cfg_i.format == FMT_SPI) |-> dout_o == s_q.word[NCH-1][WORD_W-1];
    endproperty
    a_load_msb: assert property (p_load_msb) else $error("shifter not loaded");

    property p_bypass_word;
        @(posedge clk_i) disable iff (!rst_b_i)
            (cfg_i.bypass && $stable(cfg_i) && mod_strobe_o) |-> s_q.word[0][WORD_W-1:1] == '0;
    endproperty
    a_bypass_word: assert property (p_bypass_word) else $error("bypass word not raw");

endmodule

// ===== verification/mdc_host_model.sv
// Host model that reads results from the serial data port of the decimation core
`timescale 1ns/1ps
module mdc_host_model (
    // Clock
    input  wire logic clk_i,
    // Serial port, host side
    input  wire logic dout_i,
    output logic      sclk_o,
    output logic      fsync_o,
    output logic      din_o
);
    // ****************************************************************
    // Idle levels
    // ****************************************************************
    // Serial clock stands still low between frames; the upstream chain output is held high
    initial begin
        sclk_o  = 1'b0;
        fsync_o = 1'b0;
        din_o   = 1'b1;                     // Chain bits that must follow the words
    end

    // ****************************************************************
    // Frame read
    // ****************************************************************
    // Five master clocks per bit: the core needs two to synchronise a pin edge
    // plus one for its output register, so a host with under three clocks per bit would sample stale bits
    task automatic read_frame(input bit fs, output logic [99:0] rx);
        rx = '0;
        // Frame-sync format reloads the shifter on the sync rise
        if (fs) begin
            fsync_o = 1'b1;                 // Sync pulse that reloads the shifter
        end
        repeat (5) @(posedge clk_i);
        #1;
        for (int i = 0; i < 100; i++) begin
            rx     = {rx[98:0], dout_i};    // Most significant bit first
            sclk_o = 1'b1;
            repeat (2) @(posedge clk_i);
            #1;
            sclk_o  = 1'b0;
            fsync_o = 1'b0;
            repeat (3) @(posedge clk_i);
            #1;
        end
    endtask
endmodule

// ===== verification/multichannel_decimation_core_test.sv
// Self-checking testbench for the multichannel decimation core
`timescale 1ns/1ps
module multichannel_decimation_core_test;
    import mdc_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic          clk_i;                   // Master clock, 25 ns
    logic          rst_b_i;                 // Asynchronous reset, active low
    mdc_cfg_s      cfg_i;                   // Static pins
    logic [3:0]    mod_bit_i;               // Two channels at full positive, two at full negative
    logic          sync_i;                  // External sync pin
    logic          sclk_i;
    logic          fsync_i;
    logic          din_i;
    logic          dout_o;
    logic          data_ready_b_o;
    logic          mod_strobe_o;
    logic          settled_o;
    logic [95:0]   words_o;
    int            failures;                // Mismatch counter
    int            samples_checked;         // Comparison counter
    logic [99:0]   rx;                      // Serial frame seen by the host
    logic [95:0]   exp_w;                   // Saturated words expected per channel

    // Four channels keep a frame short enough to read within one low-power period with the divide pin high
    mdc_core #(.NCH(4)) mdc_core_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg_i), .mod_bit_i(mod_bit_i),
        .sync_i(sync_i), .sclk_i(sclk_i), .fsync_i(fsync_i), .din_i(din_i), .dout_o(dout_o),
        .data_ready_b_o(data_ready_b_o), .mod_strobe_o(mod_strobe_o), .settled_o(settled_o), .words_o(words_o));
    mdc_host_model mdc_host_model_i (.clk_i(clk_i), .dout_i(dout_o), .sclk_o(sclk_i), .fsync_o(fsync_i),
        .din_o(din_i));

    // Clock generator
    always #12.5 clk_i = ~clk_i;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // One clock, then a small fixed delay so every drive and sample is off the edge
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    // Compare and count
    task automatic check(input string name, input logic [99:0] exp, input logic [99:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Wait for the falling edge of data ready, bounded; returns clocks spent
    task automatic wait_fall(input int lim, output int n);
        logic p;
        p = data_ready_b_o;
        n = 1;
        tick();
        while (!(p === 1'b1 && data_ready_b_o === 1'b0) && n <= lim) begin
            p = data_ready_b_o;
            n++;
            tick();
        end
        check("data_ready_fall", 1'b1, n <= lim);
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs under 80000 clocks; limit is 96000 clocks
    initial begin
        #2400000;
        failures++;
        wrap_up();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        mdc_profile_e pr [6];
        bit           cd [6];
        int           dv [6];
        int           n;
        int           g;
        pr = '{HIGH_SPEED_PROFILE, HIGH_RESOLUTION_PROFILE, LOW_POWER_PROFILE, LOW_POWER_PROFILE,
               LOW_SPEED_PROFILE, LOW_SPEED_PROFILE};
        cd = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        dv = '{DIV_FAST, DIV_FAST, DIV_MID, DIV_FAST, DIV_SLOW, DIV_MID};
        clk_i = 1'b0;
        rst_b_i = 1'b0;
        cfg_i = '{profile: HIGH_SPEED_PROFILE, clock_divide_select: 1'b0, bypass: 1'b0, format: FMT_SPI};
        mod_bit_i = 4'h3;
        sync_i = 1'b0;
        failures = 0;
        samples_checked = 0;
        exp_w = {CODE_NEG_MAX, CODE_NEG_MAX, CODE_POS_MAX, CODE_POS_MAX};
        repeat (2) tick();
        rst_b_i = 1'b1;
        // Every profile, and both divide pin settings for low-power and low-speed: strobe spacing and output period
        for (int k = 0; k < 6; k++) begin
            cfg_i.profile = pr[k];
            cfg_i.clock_divide_select = cd[k];
            wait_fall(6000, n);
            g = 0;
            while (mod_strobe_o !== 1'b1 && g < 100) begin
                tick();
                g++;
            end
            g = 0;
            do begin
                tick();
                g++;
            end while (mod_strobe_o !== 1'b1 && g < 100);
            check("strobe_gap", dv[k], g);
            wait_fall(6000, n);
            wait_fall(6000, n);
            check("period", dv[k] * ((pr[k] == HIGH_RESOLUTION_PROFILE) ? OSR_HRES : OSR_STD), n);
        end
        // Low-power restart, then settling count, saturation and an SPI read
        cfg_i.profile = LOW_POWER_PROFILE;
        cfg_i.clock_divide_select = 1'b1;
        for (int k = 1; k <= SETTLE_STD; k++) begin
            wait_fall(600, n);
            tick();
            tick();
            if (k >= SETTLE_STD - 1) begin
                check("settled", k == SETTLE_STD, settled_o);
            end
        end
        wait_fall(600, n);
        check("words", exp_w, words_o);
        mdc_host_model_i.read_frame(1'b0, rx);
        check("spi_frame", {exp_w, 4'hf}, rx);
        // External sync restarts the filters
        sync_i = 1'b1;
        repeat (4) tick();
        sync_i = 1'b0;
        repeat (6) tick();
        check("settled_after_sync", 1'b0, settled_o);
        // Top high-speed rate: host must use frame-sync
        cfg_i.profile = HIGH_SPEED_PROFILE;
        cfg_i.format = FMT_FRAME_SYNC;
        tick();
        check("settled_after_cfg", 1'b0, settled_o);
        n = 0;
        while (settled_o !== 1'b1 && n < 25000) begin
            tick();
            n++;
        end
        wait_fall(600, n);
        mdc_host_model_i.read_frame(1'b1, rx);
        check("fs_frame", {exp_w, 4'hf}, rx);
        // Bypass shows the raw modulator bit per channel
        cfg_i.bypass = 1'b1;
        tick();
        check("settled_bypass", 1'b0, settled_o);
        wait_fall(2000, n);
        tick();
        check("bypass_words", {24'h0, 24'h0, 24'h1, 24'h1}, words_o);
        wrap_up();
    end
endmodule
